// ===== flash_guard_map.vh
// Constants for the flash self-programming guard
`ifndef FLASH_GUARD_MAP_VH
`define FLASH_GUARD_MAP_VH
// ==========================================
// Register offsets (byte addresses)
`define FG_ADDR_CTRL 4'h0
`define FG_ADDR_STATUS 4'h4
`define FG_ADDR_LOCK 4'h8
`define FG_ADDR_ADDR 4'hc
// ==========================================
// Control register fields
`define FG_CTRL_ERASE 0
`define FG_CTRL_WRITE 1
`define FG_CTRL_LOCKSET 2
`define FG_CTRL_CHIPERASE 3
`define FG_CTRL_FROMBOOT 4
`define FG_CTRL_RDFROMBOOT 5
// ==========================================
// Status register fields
`define FG_ST_BUSY 0
`define FG_ST_STALL 1
`define FG_ST_CONCBUSY 2
`define FG_ST_REJECT 3
`define FG_ST_INTMASK 4
// ==========================================
// Lock layout and reset values
`define FG_LOCK_RESET 6'h3f
`define FG_LOCK_APPW 2
`define FG_LOCK_APPR 3
`define FG_LOCK_BOOTW 4
`define FG_LOCK_BOOTR 5
// ==========================================
// Flash geometry (word addresses)
`define FG_PAGE_WORD_BITS 6
`define FG_BOOT_START 15'h3800
`define FG_HALT_START 15'h3800
`define FG_APP_RESET 15'h0000
// ==========================================
// Timing
`define FG_CLK_HZ 10000000
`define FG_PROG_TIME_US 4000
`define FG_PROG_CYCLES 16'd40000
`endif

// ===== flash_busy_timer.v
// Programming duration timer
module flash_busy_timer #(
   parameter [15:0] CYCLES = 16'd40000
) (
   input wire ref_clk,
   input wire rst_b,
   input wire start,
   output reg busy
);
   reg [15:0] countReg;
   // ==========================================
   // Counter
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         countReg <= 16'h0000;
         busy <= 1'b0;
      end
      else if (start && !busy)
      begin
         countReg <= CYCLES - 16'h0001;
         busy <= 1'b1;
      end
      else if (busy)
      begin
         if (countReg == 16'h0000)
            busy <= 1'b0;
         else
            countReg <= countReg - 16'h0001;
      end
   end
endmodule // flash_busy_timer

// ===== flash_self_program_guard.v
// Flash self-programming guard with Wishbone registers
//
// Design decisions made here: the address map and the Wishbone register port.
`include "flash_guard_map.vh"
// Operation
// - Concurrent-section program keeps CPU running, halting-section reads
// - Halting-section program stalls CPU, no reads
// - Lock bits only cleared by chip erase or by reset
// - General lock modes never block self-programming
// - Both guard bits one means unrestricted
// - App write guard rejects app programming
// - App read guard blocks boot reads, masks interrupts
// - Boot write guard rejects boot programming
// - Boot read guard blocks app reads, masks interrupts
// - Reset vector chosen by boot vector fuse
// - Software cannot alter any fuse
// - Pointer low bits word, high bits page
// - Target address latched when operation starts
// - Lock programming ignores the flash pointer
// - Byte select bit picks byte for loads
// - Programming only honoured when the FG_CTRL_FROMBOOT bit is set in the written data
// - Concurrent busy flag high while blocked
module flash_self_program_guard #(
   parameter [15:0] PROG_CYCLES = `FG_PROG_CYCLES
) (
   input wire ref_clk,
   input wire rst_b,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire bootVectorFuse,
   input wire [15:0] flashPointer,
   input wire [14:0] fetchAddr,
   input wire loadReq,
   input wire execFromBoot,
   input wire vectorsInBoot,
   output reg [14:0] resetVector,
   output reg cpuStall,
   output reg fetchAllowed,
   output reg loadAllowed,
   output reg [14:0] loadWordAddr,
   output reg loadByteSel,
   output reg interruptMask,
   output reg concurrentSectionBusyFlag,
   output reg flashEraseStrobe,
   output reg flashWriteStrobe,
   output reg [14:0] flashPageAddr
);
   // ==========================================
   // Declarations
   reg [5:0] lockReg;
   reg [5:0] lockNext;
   reg [14:0] latchedAddrReg;
   reg targetHaltReg;
   reg rejectReg;
   reg fuseReg;
   reg fuseCapturedReg;
   reg [1:0] opKindReg;
   reg startPulse;
   wire timerBusy;
   wire wbReq;
   wire wbWrite;
   wire [14:0] ptrWord;
   wire [14:0] ptrPage;
   wire ptrBoot;
   wire ptrHalt;
   wire wantErase;
   wire wantWrite;
   wire wantLock;
   wire wantChipErase;
   wire fromBoot;
   wire guardBlocks;
   wire fetchBoot;
   wire loadBoot;
   wire holdBusy;
   wire holdHalt;

   // ==========================================
   // Functions
   function inBoot;
      input [14:0] a;
      begin
         inBoot = (a >= `FG_BOOT_START);
      end
   endfunction

   function inHalt;
      input [14:0] a;
      begin
         inHalt = (a >= `FG_HALT_START);
      end
   endfunction

   // ==========================================
   // Bus decode
   assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wbWrite = wbReq && wb_we_i && (wb_adr_i == `FG_ADDR_CTRL) && wb_sel_i[0];
   assign wantErase = wbWrite && wb_dat_i[`FG_CTRL_ERASE];
   assign wantWrite = wbWrite && wb_dat_i[`FG_CTRL_WRITE] && !wb_dat_i[`FG_CTRL_ERASE];
   assign wantLock = wbWrite && wb_dat_i[`FG_CTRL_LOCKSET];
   assign wantChipErase = wbWrite && wb_dat_i[`FG_CTRL_CHIPERASE];
   assign fromBoot = wb_dat_i[`FG_CTRL_FROMBOOT];

   // ==========================================
   // Address split
   assign ptrWord = flashPointer[15:1];
   assign ptrPage = {ptrWord[14:`FG_PAGE_WORD_BITS], {`FG_PAGE_WORD_BITS{1'b0}}};
   assign ptrBoot = inBoot(ptrPage);
   assign ptrHalt = inHalt(ptrPage);

   // Guard check; general lock bits [1:0] never consulted
   assign guardBlocks = ptrBoot ? !lockReg[`FG_LOCK_BOOTW]
                                : !lockReg[`FG_LOCK_APPW];

   // ==========================================
   // Operation start
   always @*
   begin
      startPulse = (wantErase || wantWrite) && fromBoot && !guardBlocks
                   && !timerBusy;
   end

   flash_busy_timer #(
      .CYCLES(PROG_CYCLES)
   ) u_timer (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .start(startPulse),
      .busy(timerBusy)
   );

   // ==========================================
   // Lock bits: program only to zero, chip erase restores
   always @*
   begin
      lockNext = lockReg;
      if (wantChipErase)
         lockNext = `FG_LOCK_RESET;
      else if (wantLock && fromBoot && !timerBusy)
         lockNext = lockReg & wb_dat_i[5:0];
   end

   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lockReg <= `FG_LOCK_RESET;
         latchedAddrReg <= 15'h0000;
         targetHaltReg <= 1'b0;
         rejectReg <= 1'b0;
         opKindReg <= 2'b00;
      end
      else
      begin
         lockReg <= lockNext;
         if (startPulse)
         begin
            latchedAddrReg <= ptrPage;
            targetHaltReg <= ptrHalt;
            opKindReg <= {wantWrite, wantErase};
         end
         if ((wantErase || wantWrite) && !startPulse)
            rejectReg <= 1'b1;
         else if (startPulse)
            rejectReg <= 1'b0;
      end
   end

   // ==========================================
   // Fuse capture after reset, read only
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fuseReg <= 1'b1;
         fuseCapturedReg <= 1'b0;
      end
      else if (!fuseCapturedReg)
      begin
         fuseReg <= bootVectorFuse;
         fuseCapturedReg <= 1'b1;
      end
   end

   // ==========================================
   // CPU-facing outputs
   assign fetchBoot = inBoot(fetchAddr);
   assign loadBoot = inBoot(flashPointer[15:1]);
   // Busy and target as seen from the start edge on
   assign holdBusy = timerBusy || startPulse;
   assign holdHalt = startPulse ? ptrHalt : targetHaltReg;

   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         resetVector <= `FG_APP_RESET;
         cpuStall <= 1'b0;
         fetchAllowed <= 1'b1;
         loadAllowed <= 1'b1;
         loadWordAddr <= 15'h0000;
         loadByteSel <= 1'b0;
         interruptMask <= 1'b0;
         concurrentSectionBusyFlag <= 1'b0;
         flashEraseStrobe <= 1'b0;
         flashWriteStrobe <= 1'b0;
         flashPageAddr <= 15'h0000;
      end
      else
      begin
         resetVector <= fuseReg ? `FG_APP_RESET : `FG_BOOT_START;
         cpuStall <= startPulse ? ptrHalt : (timerBusy && targetHaltReg);
         fetchAllowed <= !(holdBusy && (holdHalt || !inHalt(fetchAddr)));
         loadAllowed <= !(holdBusy && (holdHalt || !inHalt(flashPointer[15:1])))
                        && !(execFromBoot && !loadBoot && !lockReg[`FG_LOCK_APPR])
                        && !(!execFromBoot && loadBoot && !lockReg[`FG_LOCK_BOOTR]);
         loadWordAddr <= flashPointer[15:1];
         loadByteSel <= flashPointer[0];
         interruptMask <= (vectorsInBoot && !fetchBoot && !lockReg[`FG_LOCK_APPR])
                          || (!vectorsInBoot && fetchBoot && !lockReg[`FG_LOCK_BOOTR]);
         concurrentSectionBusyFlag <= holdBusy && !holdHalt;
         flashEraseStrobe <= startPulse && wantErase;
         flashWriteStrobe <= startPulse && wantWrite;
         if (startPulse)
            flashPageAddr <= ptrPage;
         else
            flashPageAddr <= latchedAddrReg;
      end
   end

   // ==========================================
   // Wishbone slave
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= wbReq;
         wb_dat_o <= 32'h00000000;
         if (wbReq && !wb_we_i)
         begin
            case (wb_adr_i)
               `FG_ADDR_STATUS:
                  wb_dat_o <= {27'h0000000, interruptMask, rejectReg,
                               concurrentSectionBusyFlag, cpuStall, timerBusy};
               `FG_ADDR_LOCK:
                  wb_dat_o <= {26'h0000000, lockReg};
               `FG_ADDR_ADDR:
                  wb_dat_o <= {15'h0000, opKindReg != 2'b00, fuseReg, latchedAddrReg};
               default:
                  wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // flash_self_program_guard

// ===== cpu_core_model.sv
// Partner model of the CPU core
module cpu_core_model (
   input wire ref_clk,
   input wire rst_b,
   input wire cpuStall,
   input wire [8:0] page,
   input wire [5:0] word,
   input wire byteSel,
   input wire execFromBoot,
   output logic [15:0] flashPointer,
   output logic [14:0] fetchAddr
);
   timeunit 1ns;
   timeprecision 1ns;
   // ======
   // Pointer and fetch
   assign flashPointer = {page, word, byteSel};
   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         fetchAddr <= 15'h3800;
      else if (!cpuStall)
         fetchAddr <= {execFromBoot ? 4'h7 : 4'h0, fetchAddr[10:0] + 11'h001};
   end
endmodule // cpu_core_model

// ===== flash_self_program_guard_monitor.sv
// Checker of the flash guard ports
module flash_self_program_guard_monitor (
   input wire ref_clk,
   input wire rst_b,
   input wire bootVectorFuse,
   input wire [15:0] flashPointer,
   input wire [14:0] resetVector,
   input wire cpuStall,
   input wire fetchAllowed,
   input wire loadAllowed,
   input wire loadByteSel,
   input wire concurrentSectionBusyFlag,
   input wire flashEraseStrobe,
   input wire flashWriteStrobe,
   input wire [14:0] flashPageAddr
);
   timeunit 1ns;
   timeprecision 1ns;
   // ======
   // Assertions
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   wire prog = flashEraseStrobe || flashWriteStrobe;
   property p_halt; cpuStall |-> !fetchAllowed && !loadAllowed; endproperty
   a_halt: assert property (p_halt) else $error("read in stall");
   property p_hold; $rose(cpuStall) |-> cpuStall [*4]; endproperty
   a_hold: assert property (p_hold) else $error("short stall");
   property p_conc; $rose(concurrentSectionBusyFlag) |-> flashPageAddr < 15'h3800; endproperty
   a_conc: assert property (p_conc) else $error("busy flag page");
   property p_cause; $rose(cpuStall) |-> flashPageAddr >= 15'h3800 && (prog || $past(prog));
   endproperty
   a_cause: assert property (p_cause) else $error("stall cause");
   property p_latch; cpuStall && $past(cpuStall) |-> $stable(flashPageAddr); endproperty
   a_latch: assert property (p_latch) else $error("page moved");
   property p_quiet; cpuStall && $past(cpuStall) |-> !prog; endproperty
   a_quiet: assert property (p_quiet) else $error("strobe in stall");
   property p_byte; $past(rst_b) |-> loadByteSel == $past(flashPointer[0]); endproperty
   a_byte: assert property (p_byte) else $error("byte select");
   property p_vec; $past(rst_b) && $past(rst_b, 2) |-> resetVector == (bootVectorFuse ?
      15'h0000 : 15'h3800); endproperty
   a_vec: assert property (p_vec) else $error("reset vector");
   c_erase: cover property (flashEraseStrobe);
   c_stall: cover property ($rose(cpuStall));
   c_conc: cover property ($rose(concurrentSectionBusyFlag));
endmodule // flash_self_program_guard_monitor
bind flash_self_program_guard flash_self_program_guard_monitor flash_self_program_guard_monitor_i (
   .ref_clk, .rst_b, .bootVectorFuse, .flashPointer, .resetVector, .cpuStall, .fetchAllowed,
   .loadAllowed, .loadByteSel, .concurrentSectionBusyFlag, .flashEraseStrobe,
   .flashWriteStrobe, .flashPageAddr);

// ===== tb_flash_self_program_guard.sv
// Testbench of the flash guard
module tb_flash_self_program_guard;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = '0, rst_b = '0, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, byteSel = '0;
   logic bootVectorFuse = '1, loadReq = '0, execFromBoot = '0, vectorsInBoot = '0;
   logic [3:0] wb_adr_i = '0, wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = '0, q;
   logic [8:0] page = '0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, cpuStall, fetchAllowed, loadAllowed, loadByteSel, interruptMask;
   wire concurrentSectionBusyFlag, flashEraseStrobe, flashWriteStrobe;
   wire [15:0] flashPointer;
   wire [14:0] fetchAddr, resetVector, flashPageAddr;
   int n_errors = 0, n_tests = 0, cycles = 0, nProg = 0, base;
   flash_self_program_guard #(.PROG_CYCLES(16'h0008)) flash_self_program_guard_i (
      .ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .bootVectorFuse, .flashPointer, .fetchAddr, .loadReq, .execFromBoot,
      .vectorsInBoot, .resetVector, .cpuStall, .fetchAllowed, .loadAllowed, .loadWordAddr(),
      .loadByteSel, .interruptMask, .concurrentSectionBusyFlag, .flashEraseStrobe,
      .flashWriteStrobe, .flashPageAddr);
   cpu_core_model cpu_core_model_i (.ref_clk, .rst_b, .cpuStall, .page, .word(6'h05), .byteSel,
      .execFromBoot, .flashPointer, .fetchAddr);
   // ======
   // Clock, strobe count, timeout
   initial
   begin
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      nProg <= nProg + int'(flashEraseStrobe | flashWriteStrobe);
      cycles++;
      if (cycles == 3000)
      begin
         n_errors++;
         results();
      end
   end
   // ======
   // Tasks
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge ref_clk); while (wb_ack_o !== 1'h1);
      r = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge ref_clk);
   endtask
   task idle;
      @(posedge ref_clk);
      do wb(1'h0, 4'h4, 32'h0, q); while (q[0] !== 1'h0);
   endtask
   task testReset(input logic f);
      rst_b <= 1'h0;
      bootVectorFuse <= f;
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'h1;
      repeat (3) @(posedge ref_clk);
      chk("resetVector", f ? 32'h0 : 32'h3800, resetVector);
      wb(1'h1, 4'hc, {32{~f}}, q);
      wb(1'h0, 4'hc, 32'h0, q);
      chk("fuse", f, q[15]);
      wb(1'h0, 4'h8, 32'h0, q);
      chk("lock", 32'h3f, q);
      $display("reset test done");
   endtask
   task testProg;
      page <= 9'h010;
      execFromBoot <= 1'h1;
      base = nProg;
      wb(1'h1, 4'h0, 32'h11, q);
      chk("strobes", 1, nProg - base);
      page <= 9'h020;
      @(negedge ref_clk);
      chk("stall", 0, cpuStall);
      chk("fetch", 1, fetchAllowed);
      chk("load", 0, loadAllowed);
      chk("busyFlag", 1, concurrentSectionBusyFlag);
      chk("page", 32'h0400, flashPageAddr);
      idle();
      page <= 9'h0e0;
      wb(1'h1, 4'h0, 32'h12, q);
      @(negedge ref_clk);
      chk("stall", 1, cpuStall);
      chk("page", 32'h3800, flashPageAddr);
      idle();
      chk("stall", 0, cpuStall);
      base = nProg;
      wb(1'h1, 4'h0, 32'h01, q);
      wb(1'h0, 4'h4, 32'h0, q);
      chk("reject", 1, q[3]);
      chk("strobes", 0, nProg - base);
      chk("stall", 0, cpuStall);
      $display("programming test done");
   endtask
   task testGuard;
      byteSel <= 1'h1;
      wb(1'h1, 4'h0, 32'h14, q);
      idle();
      wb(1'h0, 4'h8, 32'h0, q);
      chk("lock", 32'h14, q);
      page <= 9'h010;
      loadReq <= 1'h1;
      vectorsInBoot <= 1'h1;
      repeat (2) @(negedge ref_clk);
      chk("load", 0, loadAllowed);
      chk("byteSel", 1, loadByteSel);
      execFromBoot <= 1'h0;
      repeat (2) @(negedge ref_clk);
      chk("intMask", 1, interruptMask);
      page <= 9'h0e0;
      vectorsInBoot <= 1'h0;
      repeat (2) @(negedge ref_clk);
      chk("load", 0, loadAllowed);
      execFromBoot <= 1'h1;
      repeat (2) @(negedge ref_clk);
      chk("intMask", 1, interruptMask);
      base = nProg;
      idle();
      wb(1'h1, 4'h0, 32'h11, q);
      chk("strobes", 1, nProg - base);
      idle();
      wb(1'h1, 4'h0, 32'h18, q);
      wb(1'h0, 4'h8, 32'h0, q);
      chk("lock", 32'h3f, q);
      $display("guard test done");
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      testReset(1'h0);
      testReset(1'h1);
      testProg();
      testGuard();
      results();
   end
endmodule // tb_flash_self_program_guard
